// file: design/fp_special_cfg.svh
// Constants for the floating-point special-operations ALU slice.
// Assumes inclusion by its bare name from the package and design modules.
`ifndef FP_SPECIAL_CFG_SVH
`define FP_SPECIAL_CFG_SVH

`define FP_WORD_W          40
`define FP_SINGLE_W        32
`define FP_EXP_SPECIAL     8'hff
`define FP_EXP_BIAS        10'sd127
`define FP_RECIP_EXP_MAX   10'sd125
`define FP_SCALE_EXP_MAX   34'sd255
`define FP_SIGN_EXT_POS    39
`define FP_SIGN_SGL_POS    31
`define FP_ALL_ONES_EXT    40'hff_ffff_ffff
`define FP_ALL_ONES_SGL    40'h00_ffff_ffff
`define FP_SEED_W          8
`define FP_RECIP_IDX_W     7
`define FP_RSQRT_FRAC_W    6
`define FP_STATUS_RESET    8'h00

`endif

// file: design/fp_special_pkg.sv
// Types shared by the floating-point special-operations ALU slice.
// Assumes the constants header is on the include path.
`include "fp_special_cfg.svh"

package fp_special_pkg;

  typedef enum logic [2:0] {
    clip_op,
    copysign_op,
    scale_op,
    pass_op,
    reciprocal_seed_op,
    inverse_root_seed_op,
    fraction_extract_op
  } alu_op_t;

  // Common working form: single words are widened, fraction left-aligned
  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [30:0] frac;
  } fp_word_t;

  typedef struct packed {
    logic [39:0] a;
    logic [39:0] b;
  } operand_pair_t;

  typedef struct packed {
    logic zero_flag;
    logic negative_flag;
    logic overflow_flag;
    logic carry_flag;
    logic invalid_flag;
    logic sticky_underflow_flag;
    logic sticky_overflow_flag;
    logic sticky_invalid_flag;
  } block_status_t;

  typedef struct packed {
    logic zero_flag;
    logic negative_flag;
    logic overflow_flag;
    logic invalid_flag;
    logic underflow_event;
    logic overflow_event;
    logic invalid_event;
  } flag_update_t;

endpackage

// file: design/seed_lut.sv
// Seed mantissa tables for the reciprocal and inverse-root seed operations.
// Assumes purely combinational use; tables are built from constants.
`timescale 1ns/100ps
`include "fp_special_cfg.svh"
module seed_lut #(
  parameter int SEED_W = `FP_SEED_W,
  parameter int IDX_W  = `FP_RECIP_IDX_W
) (
  input  wire logic [IDX_W-1:0]  recip_idx_i,
  input  wire logic [IDX_W-1:0]  rsqrt_idx_i,
  output logic      [SEED_W-1:0] recip_seed_o,
  output logic      [SEED_W-1:0] rsqrt_seed_o
);
  import fp_special_pkg::*;

  localparam int ENTRIES = 1 << IDX_W;

  logic [SEED_W-1:0] recip_rom [ENTRIES];
  logic [SEED_W-1:0] rsqrt_rom [ENTRIES];

  // Fraction of 2/(1.f), eight bits, saturating at entry 0
  function automatic logic [SEED_W-1:0] recip_entry(input int idx);
    int v;
    v = 65536 / (ENTRIES + idx) - 256;
    if (v > 255) begin
      v = 255;
    end
    return SEED_W'(v);
  endfunction

  // Index msb is the biased exponent lsb; odd exponents take x = 1.f
  function automatic logic [SEED_W-1:0] rsqrt_entry(input int idx);
    int q;
    int r;
    int v;
    q = (64 + (idx % 64)) * ((idx >= 64) ? 64 : 128);
    r = 1;
    for (int k = 1; k < 256; k++) begin
      if (k * k <= q) begin
        r = k;
      end
    end
    v = 32768 / r - 256;
    if (v > 255) begin
      v = 255;
    end
    if (v < 0) begin
      v = 0;
    end
    return SEED_W'(v);
  endfunction

  for (genvar g = 0; g < ENTRIES; g++) begin : g_rom
    assign recip_rom[g] = recip_entry(g);
    assign rsqrt_rom[g] = rsqrt_entry(g);
  end

  assign recip_seed_o = recip_rom[recip_idx_i];
  assign rsqrt_seed_o = rsqrt_rom[rsqrt_idx_i];

endmodule

// file: design/block_flag_reg.sv
// Status register of one compute block: arithmetic and sticky flags.
// Assumes update_i is a one-cycle strobe from the operation issue logic.
`timescale 1ns/100ps
`include "fp_special_cfg.svh"
module block_flag_reg (
  input  wire logic                          clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          update_i,
  input  wire fp_special_pkg::flag_update_t  flags_i,
  output fp_special_pkg::block_status_t      status_o
);
  import fp_special_pkg::*;

  // Zero, negative, overflow, carry, invalid
  logic [4:0] arith;
  // Underflow, overflow, invalid
  logic [2:0] sticky;

  // Arithmetic flags follow the latest operation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arith <= 5'(`FP_STATUS_RESET >> 3);
    end else if (update_i) begin
      // Carry has no source in these operations
      arith <= {flags_i.zero_flag, flags_i.negative_flag, flags_i.overflow_flag, 1'b0,
                flags_i.invalid_flag};
    end
  end

  // Sticky flags only ever accumulate; only reset clears them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sticky <= 3'(`FP_STATUS_RESET);
    end else if (update_i) begin
      sticky <= sticky | {flags_i.underflow_event, flags_i.overflow_event,
                          flags_i.invalid_event};
    end
  end

  // One variable per process; the port is only a view of both
  assign status_o = {arith, sticky};

endmodule

// file: design/fp_special_ops_alu.sv
// Floating-point special-operations slice for two compute blocks (X, Y).
// Assumes operands are stable with issue_i; results appear one cycle later.
`timescale 1ns/100ps
`include "fp_special_cfg.svh"
module fp_special_ops_alu (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           issue_i,
  input  wire fp_special_pkg::alu_op_t        op_i,
  input  wire logic [1:0]                     block_sel_i,
  input  wire logic                           extended_i,
  input  wire logic                           no_flag_update_option_i,
  input  wire fp_special_pkg::operand_pair_t  x_operands_i,
  input  wire fp_special_pkg::operand_pair_t  y_operands_i,
  output logic [39:0]                         x_result_o,
  output logic [39:0]                         y_result_o,
  output logic [1:0]                          result_valid_o,
  output fp_special_pkg::block_status_t       x_block_status_o,
  output fp_special_pkg::block_status_t       y_block_status_o
);
  import fp_special_pkg::*;

  function automatic fp_word_t unpack(input logic [39:0] w, input logic ext);
    return ext ? fp_word_t'(w) : fp_word_t'({w[31:0], 8'h00});
  endfunction

  function automatic logic [39:0] pack(input fp_word_t f, input logic ext);
    return ext ? 40'(f) : {8'h00, f.sign, f.exp, f.frac[30:8]};
  endfunction

  function automatic logic [39:0] all_ones(input logic ext);
    return ext ? `FP_ALL_ONES_EXT : `FP_ALL_ONES_SGL;
  endfunction

  function automatic logic sign_of(input logic [39:0] w, input logic ext);
    return ext ? w[`FP_SIGN_EXT_POS] : w[`FP_SIGN_SGL_POS];
  endfunction

  operand_pair_t ops      [2];
  logic [39:0]   next_res [2];
  flag_update_t  next_flg [2];
  logic [39:0]   res      [2];
  block_status_t stat     [2];
  logic [1:0]    go;
  logic [1:0]    a_nan;
  logic [1:0]    b_nan;
  logic [1:0]    a_zero;

  assign ops[0] = x_operands_i;
  assign ops[1] = y_operands_i;

  for (genvar gi = 0; gi < 2; gi++) begin : g_blk
    fp_word_t          fa;
    fp_word_t          fb;
    fp_word_t          ca;
    fp_word_t          cb;
    fp_word_t          rf;
    logic              a_den;
    logic              a_inf;
    logic              b_den;
    logic [7:0]        recip_seed;
    logic [7:0]        rsqrt_seed;
    logic signed [33:0] scale_sum;
    logic signed [9:0] ne;
    logic signed [9:0] rexp;

    assign go[gi] = issue_i && block_sel_i[gi];
    assign fa     = unpack(ops[gi].a, extended_i);
    assign fb     = unpack(ops[gi].b, extended_i);
    assign a_den  = (fa.exp == 8'h00) && (fa.frac != 31'h0);
    assign b_den  = (fb.exp == 8'h00) && (fb.frac != 31'h0);
    assign a_nan[gi]  = (fa.exp == `FP_EXP_SPECIAL) && (fa.frac != 31'h0);
    assign b_nan[gi]  = (fb.exp == `FP_EXP_SPECIAL) && (fb.frac != 31'h0);
    assign a_inf      = (fa.exp == `FP_EXP_SPECIAL) && (fa.frac == 31'h0);
    assign a_zero[gi] = (fa.exp == 8'h00);
    // Denormals flushed to signed zero before any use
    assign ca = a_den ? fp_word_t'({fa.sign, 39'h0}) : fa;
    assign cb = b_den ? fp_word_t'({fb.sign, 39'h0}) : fb;

    seed_lut u_seed_lut (
      .recip_idx_i  (fa.frac[30:24]),
      .rsqrt_idx_i  ({fa.exp[0], fa.frac[30:25]}),
      .recip_seed_o (recip_seed),
      .rsqrt_seed_o (rsqrt_seed)
    );

    // Integer operand is always a single register, even in extended form
    assign scale_sum = 34'($signed({26'h0, fa.exp})) + 34'($signed(ops[gi].b[31:0]));
    assign ne        = `FP_EXP_BIAS - $signed({2'b00, fa.exp});
    assign rexp      = (ne >>> 1) - 10'sd1 + `FP_EXP_BIAS;

    always_comb begin
      rf           = ca;
      next_res[gi] = '0;
      next_flg[gi] = '0;
      case (op_i)
        clip_op: begin
          if (a_nan[gi] || b_nan[gi]) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else begin
            if ({ca.exp, ca.frac} < {cb.exp, cb.frac}) begin
              rf = ca;
            end else begin
              rf = fp_word_t'({ca.sign, cb.exp, cb.frac});
            end
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].zero_flag     = (rf.exp == 8'h00);
            next_flg[gi].negative_flag = rf.sign;
          end
        end
        copysign_op: begin
          if (a_nan[gi] || b_nan[gi]) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else begin
            rf      = ca;
            rf.sign = fb.sign;
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].zero_flag     = (rf.exp == 8'h00);
            next_flg[gi].negative_flag = rf.sign;
          end
        end
        scale_op: begin
          if (a_nan[gi]) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else if (a_zero[gi]) begin
            rf = fp_word_t'({fa.sign, 39'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].zero_flag     = 1'b1;
            next_flg[gi].negative_flag = fa.sign;
          end else if (a_inf || scale_sum >= `FP_SCALE_EXP_MAX) begin
            rf = fp_word_t'({fa.sign, `FP_EXP_SPECIAL, 31'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].negative_flag  = fa.sign;
            next_flg[gi].overflow_flag  = !a_inf;
            next_flg[gi].overflow_event = !a_inf;
          end else if (scale_sum <= 34'sd0) begin
            // Zero sum and denormal results both round to signed zero
            rf = fp_word_t'({fa.sign, 39'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].zero_flag       = 1'b1;
            next_flg[gi].negative_flag   = fa.sign;
            next_flg[gi].underflow_event = 1'b1;
          end else begin
            rf.exp = scale_sum[7:0];
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].negative_flag = fa.sign;
          end
        end
        pass_op: begin
          if (a_nan[gi]) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else begin
            next_res[gi] = pack(ca, extended_i);
            next_flg[gi].zero_flag     = (ca.exp == 8'h00);
            next_flg[gi].negative_flag = ca.sign;
          end
        end
        reciprocal_seed_op: begin
          if (a_nan[gi]) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else if (a_zero[gi]) begin
            rf = fp_word_t'({fa.sign, `FP_EXP_SPECIAL, 31'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].negative_flag  = fa.sign;
            next_flg[gi].overflow_flag  = 1'b1;
            next_flg[gi].overflow_event = 1'b1;
          end else if (-ne > `FP_RECIP_EXP_MAX) begin
            rf = fp_word_t'({fa.sign, 39'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].zero_flag     = 1'b1;
            next_flg[gi].negative_flag = fa.sign;
          end else begin
            rf.sign = fa.sign;
            rf.exp  = 8'(ne - 10'sd1 + `FP_EXP_BIAS);
            rf.frac = {recip_seed, 23'h0};
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].negative_flag = fa.sign;
          end
        end
        inverse_root_seed_op: begin
          if (a_nan[gi] || (fa.sign && !a_zero[gi])) begin
            next_res[gi] = all_ones(extended_i);
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else if (a_zero[gi]) begin
            rf = fp_word_t'({fa.sign, `FP_EXP_SPECIAL, 31'h0});
            next_res[gi] = pack(rf, extended_i);
            next_flg[gi].negative_flag  = fa.sign;
            next_flg[gi].overflow_flag  = 1'b1;
            next_flg[gi].overflow_event = 1'b1;
          end else if (a_inf) begin
            next_res[gi] = '0;
            next_flg[gi].zero_flag = 1'b1;
          end else begin
            rf.sign = fa.sign;
            rf.exp  = rexp[7:0];
            rf.frac = {rsqrt_seed, 23'h0};
            next_res[gi] = pack(rf, extended_i);
          end
        end
        fraction_extract_op: begin
          next_flg[gi].negative_flag = fa.sign;
          if (fa.exp == `FP_EXP_SPECIAL) begin
            next_res[gi] = `FP_ALL_ONES_SGL;
            next_flg[gi].invalid_flag  = 1'b1;
            next_flg[gi].invalid_event = 1'b1;
          end else if (a_zero[gi]) begin
            next_res[gi] = '0;
            next_flg[gi].zero_flag = 1'b1;
          end else begin
            // Exact by construction, so no rounding path exists
            next_res[gi] = {8'h00, 1'b1, fa.frac};
          end
        end
        default: begin
          next_res[gi] = '0;
        end
      endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        res[gi] <= '0;
      end else if (go[gi]) begin
        res[gi] <= next_res[gi];
      end
    end

    block_flag_reg u_flag_reg (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .update_i (go[gi] && !no_flag_update_option_i),
      .flags_i  (next_flg[gi]),
      .status_o (stat[gi])
    );

    property p_clip_nan;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && op_i == clip_op && (a_nan[gi] || b_nan[gi])
        |=> res[gi] == all_ones($past(extended_i));
    endproperty
    a_clip_nan: assert property (p_clip_nan) else $error("clip NaN not all ones");

    property p_copysign_sign;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && op_i == copysign_op && !a_nan[gi] && !b_nan[gi]
        |=> sign_of(res[gi], $past(extended_i)) == $past(sign_of(ops[gi].b, extended_i));
    endproperty
    a_copysign_sign: assert property (p_copysign_sign) else $error("copysign sign wrong");

    property p_nf_freeze;
      @(posedge clk_i) disable iff (!arst_n_i)
      !(go[gi] && !no_flag_update_option_i) |=> $stable(stat[gi]);
    endproperty
    a_nf_freeze: assert property (p_nf_freeze) else $error("status moved without update");

    property p_sticky_keep;
      @(posedge clk_i) disable iff (!arst_n_i)
      stat[gi].sticky_invalid_flag |=> stat[gi].sticky_invalid_flag ##1 stat[gi].sticky_invalid_flag;
    endproperty
    a_sticky_keep: assert property (p_sticky_keep) else $error("sticky invalid cleared");

    property p_recip_zero;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && !no_flag_update_option_i && op_i == reciprocal_seed_op && a_zero[gi] && !a_nan[gi]
        |=> stat[gi].overflow_flag && stat[gi].sticky_overflow_flag;
    endproperty
    a_recip_zero: assert property (p_recip_zero) else $error("reciprocal zero no overflow");

    property p_rsqrt_neg;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && !no_flag_update_option_i && op_i == inverse_root_seed_op
        && fa.sign && !a_zero[gi]
        |=> stat[gi].invalid_flag && stat[gi].sticky_invalid_flag && !stat[gi].negative_flag;
    endproperty
    a_rsqrt_neg: assert property (p_rsqrt_neg) else $error("inverse root negative input");

    property p_fraction_hidden;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && op_i == fraction_extract_op && !a_zero[gi] && fa.exp != `FP_EXP_SPECIAL
        |=> res[gi][31] && res[gi][39:32] == 8'h00;
    endproperty
    a_fraction_hidden: assert property (p_fraction_hidden) else $error("hidden bit missing");

    property p_pass_clear;
      @(posedge clk_i) disable iff (!arst_n_i)
      go[gi] && !no_flag_update_option_i && op_i == pass_op
        |=> !stat[gi].overflow_flag && !stat[gi].carry_flag
            && stat[gi].sticky_overflow_flag == $past(stat[gi].sticky_overflow_flag);
    endproperty
    a_pass_clear: assert property (p_pass_clear) else $error("pass flags wrong");

    property p_unselected_hold;
      @(posedge clk_i) disable iff (!arst_n_i)
      !go[gi] |=> $stable(res[gi]) && $stable(stat[gi]);
    endproperty
    a_unselected_hold: assert property (p_unselected_hold) else $error("idle block changed");
  end

  // Valid mirrors the issue strobe per block, one cycle later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_valid_o <= 2'h0;
    end else begin
      result_valid_o <= go;
    end
  end

  assign x_result_o       = res[0];
  assign y_result_o       = res[1];
  assign x_block_status_o = stat[0];
  assign y_block_status_o = stat[1];

endmodule

// file: tb/operand_source.sv
// Register-file and issue model facing the special-operations slice.
// Assumes go_i is held high for exactly one clock by the bench.
`timescale 1ns/100ps
module operand_source (
  input  wire logic                          clk_i,
  input  wire logic                          go_i,
  input  wire fp_special_pkg::operand_pair_t x_i,
  input  wire fp_special_pkg::operand_pair_t y_i,
  output logic                               issue_o,
  output fp_special_pkg::operand_pair_t      x_o,
  output fp_special_pkg::operand_pair_t      y_o
);
  import fp_special_pkg::*;
  // Operands hold like register contents until the next load
  always_ff @(posedge clk_i) begin
    issue_o <= go_i;
    if (go_i) begin
      x_o <= x_i;
      y_o <= y_i;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the special-operations slice, both blocks.
// Assumes the package and operand_source model are compiled first.
`timescale 1ns/100ps
module tb;
  import fp_special_pkg::*;
  logic          clk_i    = 1'b0;
  logic          arst_n_i = 1'b0;
  logic          go       = 1'b0;
  logic          issue;
  alu_op_t       op       = clip_op;
  logic [1:0]    sel      = 2'b00;
  logic          ext      = 1'b0;
  logic          nf       = 1'b0;
  operand_pair_t xin      = '0;
  operand_pair_t yin      = '0;
  operand_pair_t xop;
  operand_pair_t yop;
  logic [39:0]   xr;
  logic [39:0]   yr;
  logic [1:0]    vld;
  block_status_t xs;
  block_status_t ys;
  int            err_total = 0;
  int            tests_run = 0;

  always #20 clk_i = ~clk_i;

  operand_source i_src (.clk_i(clk_i), .go_i(go), .x_i(xin), .y_i(yin),
                        .issue_o(issue), .x_o(xop), .y_o(yop));

  fp_special_ops_alu i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .issue_i(issue), .op_i(op),
    .block_sel_i(sel), .extended_i(ext), .no_flag_update_option_i(nf),
    .x_operands_i(xop), .y_operands_i(yop), .x_result_o(xr), .y_result_o(yr),
    .result_valid_o(vld), .x_block_status_o(xs), .y_block_status_o(ys));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_s(input string w, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  function automatic logic [79:0] p(input logic [31:0] a, input logic [31:0] b);
    return {8'h00, a, 8'h00, b};
  endfunction

  task automatic run(input alu_op_t o, input logic [1:0] s, input logic e,
                     input logic n, input logic [79:0] x, input logic [79:0] y);
    int k;
    @(negedge clk_i);
    go = 1'b1;
    op = o;
    sel = s;
    ext = e;
    nf = n;
    xin = x;
    yin = y;
    @(negedge clk_i);
    go = 1'b0;
    for (k = 0; k < 4 && vld === 2'b00; k++) @(posedge clk_i) #1;
    if (vld === 2'b00) begin
      err_total++;
      $display("mismatch valid timeout expected %h seen %h", s, vld);
      finish_test();
    end
    chk("valid", {38'h0, s}, {38'h0, vld});
  endtask

  task automatic ex4(input logic [39:0] a, input logic [7:0] b,
                     input logic [39:0] c, input logic [7:0] d);
    chk("x result", a, xr);
    chk_s("x status", b, xs);
    chk("y result", c, yr);
    chk_s("y status", d, ys);
  endtask

  task automatic t_clip_copy;
    run(clip_op, 2'b11, 0, 0, p(32'h3f800000, 32'hc0000000), p(32'hc0400000, 32'h40000000));
    ex4(40'h3f800000, 8'h00, 40'hc0000000, 8'h40);
    run(clip_op, 2'b11, 0, 0, p(32'h7fc00000, 32'h40000000), p(32'h00000001, 32'h40000000));
    ex4(40'hffffffff, 8'h09, 40'h0, 8'h80);
    run(copysign_op, 2'b11, 0, 0, p(32'h3f800000, 32'hc0000000), p(32'h5, 32'h80000000));
    ex4(40'hbf800000, 8'h41, 40'h80000000, 8'hc0);
    $display("test clip and copysign done");
  endtask

  task automatic t_scale_pass;
    run(scale_op, 2'b11, 0, 0, p(32'h3f800000, 32'h2), p(32'h3f800000, 32'h80));
    ex4(40'h40800000, 8'h01, 40'h7f800000, 8'h22);
    run(scale_op, 2'b10, 0, 1, p(32'h3f800000, 32'h0), p(32'h3f800000, 32'hffffff81));
    ex4(40'h40800000, 8'h01, 40'h0, 8'h22);
    run(scale_op, 2'b10, 0, 0, p(32'h3f800000, 32'h0), p(32'h3f800000, 32'hffffff81));
    ex4(40'h40800000, 8'h01, 40'h0, 8'h86);
    run(pass_op, 2'b11, 1, 0, {40'h3f80000000, 40'h0}, {40'h7fc0000000, 40'h0});
    ex4(40'h3f80000000, 8'h01, 40'hffffffffff, 8'h0f);
    $display("test scale and pass done");
  endtask

  task automatic t_seeds;
    run(reciprocal_seed_op, 2'b11, 0, 0, p(32'h0, 32'h0), p(32'hc0800000, 32'h0));
    chk("x recip", 40'h7f800000, xr);
    chk_s("x status", 8'h23, xs);
    chk("y recip exp", 40'h17c, {31'h0, yr[31:23]});
    chk_s("y status", 8'h47, ys);
    run(inverse_root_seed_op, 2'b11, 0, 0, p(32'hbf800000, 32'h0), p(32'h80000000, 32'h0));
    ex4(40'hffffffff, 8'h0b, 40'hff800000, 8'h67);
    run(inverse_root_seed_op, 2'b01, 0, 0, p(32'h40800000, 32'h0), p(32'h0, 32'h0));
    chk("x rsqrt exp", 40'h07d, {31'h0, xr[31:23]});
    chk_s("x status", 8'h03, xs);
    run(reciprocal_seed_op, 2'b11, 0, 0, p(32'h3f800000, 32'h0), p(32'h3f80ffff, 32'h0));
    chk("recip low bits ignored", xr, yr);
    chk("x recip exp", 40'h07e, {31'h0, xr[31:23]});
    run(inverse_root_seed_op, 2'b11, 0, 0, p(32'h40800000, 32'h0), p(32'h4081ffff, 32'h0));
    chk("rsqrt low bits ignored", xr, yr);
    run(reciprocal_seed_op, 2'b11, 0, 0, p(32'h7f000000, 32'h0), p(32'hfe800000, 32'h0));
    ex4(40'h0, 8'h83, 40'h80000000, 8'hc7);
    run(inverse_root_seed_op, 2'b11, 0, 0, p(32'h7f800000, 32'h0), p(32'h00000001, 32'h0));
    ex4(40'h0, 8'h83, 40'h7f800000, 8'h27);
    run(fraction_extract_op, 2'b11, 0, 0, p(32'hbfc00000, 32'h0), p(32'h7f800000, 32'h0));
    ex4(40'hc0000000, 8'h43, 40'hffffffff, 8'h0f);
    $display("test seeds and fraction done");
  endtask

  initial begin
    repeat (4) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_clip_copy();
    t_scale_pass();
    t_seeds();
    finish_test();
  end
endmodule
